/* File: rtl/rsu_pkg.sv */
`default_nettype none
package rsu_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_MHZ          = 25;
  localparam int unsigned NS_PER_US        = 1000;
  localparam int unsigned REQ_MIN_NS       = 250;
  // least time, so rounded up to whole cycles
  localparam int unsigned REQ_MIN_CYCLES   = (REQ_MIN_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int unsigned PIN_MIN_CYCLES   = 1;
  localparam int unsigned FILT_CNT_W       = 8;
  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned PAGE_W           = 24;
  localparam int unsigned TIMER_W          = 12;
  localparam int unsigned CTRL_W           = 38;
  localparam int unsigned CTRL_HI_W        = CTRL_W - DATA_W;
  localparam int unsigned WD_CNT_W         = 29;
  localparam int unsigned WD_SHIFT_DEFAULT = 17;
  localparam int unsigned CAUSE_W          = 5;
  localparam int unsigned EVT_W            = 3;
  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [ADDR_W-1:0] REG_UPDATE_LO   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_UPDATE_HI   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_READBACK_LO = 8'h08;
  localparam logic [ADDR_W-1:0] REG_READBACK_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_CAUSE       = 8'h10;
  localparam logic [ADDR_W-1:0] REG_EVENT       = 8'h14;
  localparam logic [ADDR_W-1:0] REG_MASK        = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STATE       = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_WD_COUNT    = 8'h20;
  ////////////////////////////////////////////////////////////////////////////
  // event bits
  localparam int unsigned EVT_RECONFIG = 0;
  localparam int unsigned EVT_WDOG     = 1;
  localparam int unsigned EVT_USER     = 2;
  // state register bits
  localparam int unsigned ST_USER_BIT  = 0;
  localparam int unsigned ST_APP_BIT   = 1;
  localparam int unsigned ST_WD_BIT    = 2;
  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    RSU_CONFIGURING,
    RSU_USER
  } rsu_phase_t;

  // bit 37 down to bit 0: timer, watchdog enable, page, application flag
  typedef struct packed {
    logic [TIMER_W-1:0] wd_timer;
    logic               wd_en;
    logic [PAGE_W-1:0]  page;
    logic               app;
  } rsu_ctrl_t;

  // bit 4 down to bit 0
  typedef struct packed {
    logic watchdog_cause_flag;
    logic ext_reload;
    logic fabric;
    logic ext_error;
    logic crc;
  } rsu_cause_t;

  localparam rsu_ctrl_t  CTRL_RESET  = '0;
  localparam rsu_cause_t CAUSE_RESET = '0;
endpackage
`default_nettype wire

/* File: rtl/rsu_reconfig_ctrl.sv */
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rsu_reconfig_ctrl #(
  parameter int unsigned WD_SHIFT = rsu_pkg::WD_SHIFT_DEFAULT
) (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       reset_in,
  // register port
  input  wire logic [rsu_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [rsu_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                       write_in,
  input  wire logic                       read_in,
  output logic      [rsu_pkg::DATA_W-1:0] rdata_out,
  // requests and events from outside the clock domain
  input  wire logic                       fabric_reload_request_n_in,
  input  wire logic                       watchdog_clear_request_n_in,
  input  wire logic                       external_reload_request_n_in,
  input  wire logic                       external_error_pulse_n_in,
  input  wire logic                       crc_error_in,
  input  wire logic                       config_done_in,
  // image load control and status
  output logic                            load_start_out,
  output logic      [rsu_pkg::PAGE_W-1:0] load_page_out,
  output logic                            app_image_out,
  output logic                            user_mode_out,
  output logic                            watchdog_timeout_out,
  output logic                            watchdog_cause_flag_out,
  // interrupt
  output logic                            irq_out
);
  typedef struct packed {
    rsu_pkg::rsu_phase_t                phase;
    rsu_pkg::rsu_ctrl_t                 ctrl;
    rsu_pkg::rsu_ctrl_t                 upd;
    rsu_pkg::rsu_cause_t                cause;
    logic [rsu_pkg::WD_CNT_W-1:0]       wd_cnt;
    logic [rsu_pkg::EVT_W-1:0]          evt;
    logic [rsu_pkg::EVT_W-1:0]          mask;
    logic [rsu_pkg::DATA_W-1:0]         rdata;
    logic                               load_pend;
    logic                               load_pulse;
    logic                               tmo_pulse;
  } rsu_state_t;

  localparam rsu_state_t STATE_RESET = '{phase: rsu_pkg::RSU_CONFIGURING,
                                         ctrl: rsu_pkg::CTRL_RESET,
                                         upd: rsu_pkg::CTRL_RESET,
                                         cause: rsu_pkg::CAUSE_RESET,
                                         default: '0};

  rsu_state_t q_reg;
  rsu_state_t q_next;

  ////////////////////////////////////////////////////////////////////////////
  // input qualification
  logic fabric_hit;
  logic clear_hit;
  logic ext_reload_hit;
  logic ext_error_hit;
  logic crc_hit;
  logic done_hit;

  rsu_req_filter #(.MIN_CYCLES(rsu_pkg::REQ_MIN_CYCLES)) u_fabric (
    .clk_in  (clk_in),
    .reset_in(reset_in),
    .req_n_in(fabric_reload_request_n_in),
    .hit_out (fabric_hit)
  );
  rsu_req_filter #(.MIN_CYCLES(rsu_pkg::REQ_MIN_CYCLES)) u_clear (
    .clk_in  (clk_in),
    .reset_in(reset_in),
    .req_n_in(watchdog_clear_request_n_in),
    .hit_out (clear_hit)
  );
  rsu_req_filter #(.MIN_CYCLES(rsu_pkg::PIN_MIN_CYCLES)) u_ext_reload (
    .clk_in  (clk_in),
    .reset_in(reset_in),
    .req_n_in(external_reload_request_n_in),
    .hit_out (ext_reload_hit)
  );
  rsu_req_filter #(.MIN_CYCLES(rsu_pkg::PIN_MIN_CYCLES)) u_ext_error (
    .clk_in  (clk_in),
    .reset_in(reset_in),
    .req_n_in(external_error_pulse_n_in),
    .hit_out (ext_error_hit)
  );
  // active-high inputs are inverted ahead of the synchroniser
  rsu_req_filter #(.MIN_CYCLES(rsu_pkg::PIN_MIN_CYCLES)) u_crc (
    .clk_in  (clk_in),
    .reset_in(reset_in),
    .req_n_in(~crc_error_in),
    .hit_out (crc_hit)
  );
  rsu_req_filter #(.MIN_CYCLES(rsu_pkg::PIN_MIN_CYCLES)) u_done (
    .clk_in  (clk_in),
    .reset_in(reset_in),
    .req_n_in(~config_done_in),
    .hit_out (done_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [rsu_pkg::DATA_W-1:0] word_of(input rsu_pkg::rsu_ctrl_t v,
                                                        input logic hi);
    logic [rsu_pkg::CTRL_W-1:0] flat;
    flat = v;
    if (hi) begin
      return rsu_pkg::DATA_W'(flat[rsu_pkg::CTRL_W-1:rsu_pkg::DATA_W]);
    end
    return flat[rsu_pkg::DATA_W-1:0];
  endfunction

  function automatic logic [rsu_pkg::WD_CNT_W-1:0] wd_load(
      input logic [rsu_pkg::TIMER_W-1:0] timer);
    logic [rsu_pkg::WD_CNT_W-1:0] t;
    t = rsu_pkg::WD_CNT_W'(timer);
    return t << WD_SHIFT;
  endfunction

  logic                running;
  logic                wd_expire;
  logic                trigger;
  logic                evt_read;
  rsu_pkg::rsu_cause_t cause_now;
  // flat view of the update register, so each half can be kept on a write
  logic [rsu_pkg::CTRL_W-1:0] upd_flat;

  // off unless app in user mode
  assign running   = (q_reg.phase == rsu_pkg::RSU_USER) && q_reg.ctrl.app && q_reg.ctrl.wd_en;
  assign wd_expire = running && (q_reg.wd_cnt == '0);
  assign evt_read  = read_in && (addr_in == rsu_pkg::REG_EVENT);
  assign upd_flat  = q_reg.upd;

  ////////////////////////////////////////////////////////////////////////////
  // cause priority
  always_comb begin
    cause_now = rsu_pkg::CAUSE_RESET;
    if (ext_reload_hit) begin
      cause_now.ext_reload = 1'b1;
    end else if (ext_error_hit) begin
      cause_now.ext_error = 1'b1;
    end else if (crc_hit) begin
      cause_now.crc = 1'b1;
    end else if (wd_expire) begin
      cause_now.watchdog_cause_flag = 1'b1;
    end else if (fabric_hit) begin
      cause_now.fabric = 1'b1;
    end
  end
  assign trigger = |cause_now;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    q_next            = q_reg;
    q_next.load_pulse = q_reg.load_pend;
    q_next.load_pend  = 1'b0;
    q_next.tmo_pulse  = wd_expire;
    q_next.rdata      = '0;

    if (trigger) begin
      q_next.cause     = cause_now;
      q_next.load_pend = 1'b1;
      q_next.phase     = rsu_pkg::RSU_CONFIGURING;
      q_next.ctrl      = cause_now.fabric ? q_reg.upd : rsu_pkg::CTRL_RESET;
    end else begin
      case (q_reg.phase)
        rsu_pkg::RSU_CONFIGURING: begin
          if (done_hit && !q_reg.load_pend) begin
            q_next.phase = rsu_pkg::RSU_USER;
          end
        end
        rsu_pkg::RSU_USER: begin
        end
        default: begin
          q_next.phase = rsu_pkg::RSU_CONFIGURING;
        end
      endcase
    end

    if (trigger || q_reg.phase != rsu_pkg::RSU_USER) begin
      q_next.wd_cnt = wd_load(q_reg.ctrl.wd_timer);
    end else if (running && clear_hit) begin
      q_next.wd_cnt = wd_load(q_reg.ctrl.wd_timer);
    end else if (running) begin
      q_next.wd_cnt = q_reg.wd_cnt - rsu_pkg::WD_CNT_W'(1);
    end

    // update register is writable only from the factory image
    if (write_in && !q_reg.ctrl.app) begin
      if (addr_in == rsu_pkg::REG_UPDATE_LO) begin
        q_next.upd = rsu_pkg::rsu_ctrl_t'({upd_flat[rsu_pkg::CTRL_W-1:rsu_pkg::DATA_W],
                                           wdata_in});
      end else if (addr_in == rsu_pkg::REG_UPDATE_HI) begin
        q_next.upd = rsu_pkg::rsu_ctrl_t'({wdata_in[rsu_pkg::CTRL_HI_W-1:0],
                                           upd_flat[rsu_pkg::DATA_W-1:0]});
      end
    end
    if (write_in && addr_in == rsu_pkg::REG_MASK) begin
      q_next.mask = wdata_in[rsu_pkg::EVT_W-1:0];
    end

    // read clears events, a same-cycle event still sets
    q_next.evt = evt_read ? '0 : q_reg.evt;
    q_next.evt[rsu_pkg::EVT_RECONFIG] = q_next.evt[rsu_pkg::EVT_RECONFIG] | trigger;
    q_next.evt[rsu_pkg::EVT_WDOG]     = q_next.evt[rsu_pkg::EVT_WDOG] | wd_expire;
    q_next.evt[rsu_pkg::EVT_USER]     = q_next.evt[rsu_pkg::EVT_USER] |
                                        (!trigger && done_hit && !q_reg.load_pend &&
                                         q_reg.phase == rsu_pkg::RSU_CONFIGURING);

    if (read_in) begin
      case (addr_in)
        rsu_pkg::REG_UPDATE_LO:   q_next.rdata = word_of(q_reg.upd, 1'b0);
        rsu_pkg::REG_UPDATE_HI:   q_next.rdata = word_of(q_reg.upd, 1'b1);
        rsu_pkg::REG_READBACK_LO: q_next.rdata = word_of(q_reg.ctrl.app ? q_reg.ctrl : q_reg.upd,
                                                         1'b0);
        rsu_pkg::REG_READBACK_HI: q_next.rdata = word_of(q_reg.ctrl.app ? q_reg.ctrl : q_reg.upd,
                                                         1'b1);
        rsu_pkg::REG_CAUSE:       q_next.rdata = rsu_pkg::DATA_W'(q_reg.cause);
        rsu_pkg::REG_EVENT:       q_next.rdata = rsu_pkg::DATA_W'(q_reg.evt);
        rsu_pkg::REG_MASK:        q_next.rdata = rsu_pkg::DATA_W'(q_reg.mask);
        rsu_pkg::REG_STATE: begin
          q_next.rdata[rsu_pkg::ST_USER_BIT] = (q_reg.phase == rsu_pkg::RSU_USER);
          q_next.rdata[rsu_pkg::ST_APP_BIT]  = q_reg.ctrl.app;
          q_next.rdata[rsu_pkg::ST_WD_BIT]   = running;
        end
        rsu_pkg::REG_WD_COUNT:    q_next.rdata = rsu_pkg::DATA_W'(q_reg.wd_cnt);
        default:                  q_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q_reg <= STATE_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_out               = q_reg.rdata;
  assign load_start_out          = q_reg.load_pulse;
  assign load_page_out           = q_reg.ctrl.page;
  assign app_image_out           = q_reg.ctrl.app;
  assign user_mode_out           = (q_reg.phase == rsu_pkg::RSU_USER);
  assign watchdog_timeout_out    = q_reg.tmo_pulse;
  assign watchdog_cause_flag_out = q_reg.cause.watchdog_cause_flag;
  // level output, drops when the event register is read
  assign irq_out                 = |(q_reg.evt & q_reg.mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence seq_err_trigger;
    ext_reload_hit || ext_error_hit || crc_hit || wd_expire;
  endsequence
  sequence seq_cause_then_load;
    (q_reg.cause != '0 && !load_start_out) ##1 (load_start_out && q_reg.cause != '0);
  endsequence

  cause_before_load_a: assert property (trigger |=> seq_cause_then_load)
    else $error("cause not recorded ahead of image load");
  ctrl_zeroed_a: assert property (seq_err_trigger |=> q_reg.ctrl == '0)
    else $error("control not cleared after error trigger");
  ctrl_copied_a: assert property (cause_now.fabric |=> q_reg.ctrl == $past(q_reg.upd))
    else $error("control not loaded from update register");
  cause_priority_a: assert property ((ext_reload_hit && fabric_hit) |=>
                                     (q_reg.cause.ext_reload && !app_image_out))
    else $error("fabric trigger overrode external reload");
  capture_update_a: assert property ((read_in && addr_in == rsu_pkg::REG_READBACK_LO &&
                                      !q_reg.ctrl.app) |=>
                                     rdata_out == $past(q_reg.upd[rsu_pkg::DATA_W-1:0]))
    else $error("factory readback did not return update register");
  read_control_a: assert property ((read_in && addr_in == rsu_pkg::REG_READBACK_LO &&
                                    q_reg.ctrl.app) |=>
                                   rdata_out == $past(q_reg.ctrl[rsu_pkg::DATA_W-1:0]))
    else $error("application readback did not return control register");
  wd_countdown_a: assert property ((running && q_reg.wd_cnt != '0 && !clear_hit && !trigger)
                                   |=> q_reg.wd_cnt == $past(q_reg.wd_cnt) - rsu_pkg::WD_CNT_W'(1))
    else $error("watchdog did not step down by one");
  wd_reload_a: assert property ((running && clear_hit && !trigger) |=>
                                q_reg.wd_cnt == wd_load($past(q_reg.ctrl.wd_timer)))
    else $error("watchdog reload value wrong");
  // a higher-priority trigger in the same cycle takes the cause instead
  wd_expiry_a: assert property ((wd_expire && cause_now.watchdog_cause_flag) |=>
                                (watchdog_timeout_out &&
                                watchdog_cause_flag_out && q_reg.ctrl == '0) ##1 load_start_out)
    else $error("watchdog expiry did not reload factory image");
  // the timeout pulse itself stands in the first cycle after leaving user mode
  wd_idle_a: assert property ((!user_mode_out || !app_image_out) |-> !running
                              ##1 !watchdog_timeout_out)
    else $error("watchdog active outside application user mode");
  wd_start_a: assert property ($rose(running) |-> $past(q_reg.phase) == rsu_pkg::RSU_CONFIGURING
                               || $past(q_reg.ctrl.app) == 1'b0 || !$past(q_reg.ctrl.wd_en))
    else $error("watchdog started without entering user mode");
endmodule
`default_nettype wire

/* File: rtl/rsu_req_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module rsu_req_filter #(
  parameter int unsigned MIN_CYCLES = 1
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // request pin, active low
  input  wire logic req_n_in,
  // one-cycle pulse once the request has been held long enough
  output logic      hit_out
);
  localparam logic [rsu_pkg::FILT_CNT_W-1:0] CNT_LAST = rsu_pkg::FILT_CNT_W'(MIN_CYCLES - 1);

  typedef struct packed {
    logic                          meta;
    logic                          sync;
    logic [rsu_pkg::FILT_CNT_W-1:0] held;
    logic                          fired;
    logic                          hit;
  } rsu_filt_state_t;

  localparam rsu_filt_state_t FILT_RESET = '{meta: 1'b1, sync: 1'b1, held: '0,
                                             fired: 1'b0, hit: 1'b0};

  rsu_filt_state_t q_reg;
  rsu_filt_state_t q_next;

  ////////////////////////////////////////////////////////////////////////////
  // sync then width
  always_comb begin
    q_next      = q_reg;
    q_next.meta = req_n_in;
    q_next.sync = q_reg.meta;
    q_next.hit  = 1'b0;
    if (q_reg.sync) begin
      q_next.held  = '0;
      q_next.fired = 1'b0;
    end else if (!q_reg.fired) begin
      if (q_reg.held == CNT_LAST) begin
        q_next.fired = 1'b1;
        q_next.hit   = 1'b1;
      end else begin
        q_next.held = q_reg.held + rsu_pkg::FILT_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q_reg <= FILT_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  assign hit_out = q_reg.hit;
endmodule
`default_nettype wire

/* File: verification/rsu_fabric_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rsu_fabric_model (
  // clock
  input  wire logic clk_in,
  // requests to the block, active low
  output var logic  reload_n_out,
  output var logic  clear_n_out
);
  initial begin
    reload_n_out = 1'b1;
    clear_n_out  = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // the caller picks the width; a short one is only asked for on purpose
  // reload held low
  task automatic pulse_reload(input int n);
    @(posedge clk_in);
    reload_n_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    reload_n_out <= 1'b1;
  endtask
  task automatic pulse_clear(input int n);
    @(posedge clk_in);
    clear_n_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    clear_n_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int WDS = 3;
  logic               clk_in   = 1'b0;
  logic               reset_in = 1'b1;
  logic [7:0]         addr     = 8'h00;
  logic [31:0]        wdata    = 32'h0000_0000;
  logic               wr       = 1'b0;
  logic               rd       = 1'b0;
  logic [2:0]         err_act  = 3'b000;
  logic               done     = 1'b0;
  logic [31:0]        rdata;
  logic [31:0]        d;
  logic [23:0]        load_page;
  logic               rl_n;
  logic               cl_n;
  logic               load_start;
  logic               app_image;
  logic               user_mode;
  logic               wd_to;
  logic               wd_flag;
  logic               irq;
  int                 fails      = 0;
  int                 num_checks = 0;
  int                 cycles     = 0;
  int                 to_seen    = 0;
  int                 ls_seen    = 0;
  rsu_pkg::rsu_ctrl_t cfg;

  always #20 clk_in = ~clk_in;

  // short shift keeps watchdog runs to a few dozen cycles
  rsu_reconfig_ctrl #(.WD_SHIFT(WDS)) rsu_reconfig_ctrl_inst (
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata),
    .write_in(wr), .read_in(rd), .rdata_out(rdata),
    .fabric_reload_request_n_in(rl_n), .watchdog_clear_request_n_in(cl_n),
    .external_reload_request_n_in(~err_act[0]),
    .external_error_pulse_n_in(~err_act[1]), .crc_error_in(err_act[2]),
    .config_done_in(done), .load_start_out(load_start),
    .load_page_out(load_page), .app_image_out(app_image),
    .user_mode_out(user_mode), .watchdog_timeout_out(wd_to),
    .watchdog_cause_flag_out(wd_flag), .irq_out(irq));

  rsu_fabric_model rsu_fabric_model_inst (
    .clk_in(clk_in), .reload_n_out(rl_n), .clear_n_out(cl_n));

  ////////////////////////////////////////////////////////////////////////////
  // pulses are counted on the falling edge, clear of the launching edge
  always @(negedge clk_in) begin
    cycles++;
    if (wd_to === 1'b1) to_seen++;
    if (load_start === 1'b1) ls_seen++;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic arm_app();
    wreg(rsu_pkg::REG_UPDATE_LO, cfg[31:0]);
    wreg(rsu_pkg::REG_UPDATE_HI, {26'h0, cfg[37:32]});
  endtask

  task automatic wait_load();
    for (int k = 0; k < 60; k++) begin
      @(posedge clk_in);
      #1;
      if (load_start === 1'b1) break;
    end
    check("load_start", load_start, 1'b1);
  endtask

  task automatic enter_user();
    @(posedge clk_in);
    done <= 1'b1;
    for (int k = 0; k < 20; k++) begin
      @(posedge clk_in);
      #1;
      if (user_mode === 1'b1) break;
    end
    @(posedge clk_in);
    done <= 1'b0;
    check("user_mode", user_mode, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_regs();
    logic [7:0] ro [6] = '{rsu_pkg::REG_CAUSE, rsu_pkg::REG_READBACK_LO,
      rsu_pkg::REG_READBACK_HI, rsu_pkg::REG_STATE, rsu_pkg::REG_WD_COUNT, 8'h24};
    check("outputs", {load_start, app_image, user_mode, wd_to, wd_flag, irq}, 6'h00);
    foreach (ro[i]) begin
      wreg(ro[i], 32'hFFFF_FFFF);
      rreg(ro[i], d);
      check("ro_reg", d, 32'h0000_0000);
    end
  endtask

  task automatic t_irq();
    enter_user();
    check("irq_masked", irq, 1'b0);
    wreg(rsu_pkg::REG_MASK, 32'h0000_0004);
    #1 check("irq_on", irq, 1'b1);
    rreg(rsu_pkg::REG_EVENT, d);
    check("event_user", d, 32'h0000_0004);
    check("irq_off", irq, 1'b0);
    rreg(rsu_pkg::REG_EVENT, d);
    check("event_clear", d, 32'h0000_0000);
    wreg(rsu_pkg::REG_MASK, 32'h0000_0000);
  endtask

  task automatic t_fabric();
    int n;
    arm_app();
    n = ls_seen;
    rsu_fabric_model_inst.pulse_reload(6);
    repeat (20) @(posedge clk_in);
    check("short_reload", ls_seen, n);
    rsu_fabric_model_inst.pulse_reload(7);
    wait_load();
    rreg(rsu_pkg::REG_CAUSE, d);
    check("cause_fabric", d, 32'h0000_0004);
    check("page_fabric", load_page, cfg.page);
    check("app_fabric", app_image, 1'b1);
    rreg(rsu_pkg::REG_WD_COUNT, d);
    check("wd_load", d, 32'(cfg.wd_timer) << WDS);
    // a refused update write must leave the readback untouched
    wreg(rsu_pkg::REG_UPDATE_LO, 32'h0000_0000);
    rreg(rsu_pkg::REG_READBACK_LO, d);
    check("readback_app", d, cfg[31:0]);
  endtask

  task automatic t_expiry();
    int n;
    int t;
    t = to_seen;
    repeat (50) @(posedge clk_in);
    check("wd_cfg_idle", to_seen, t);
    enter_user();
    for (n = 1; n < 80; n++) begin
      @(posedge clk_in);
      #1;
      if (wd_to === 1'b1) break;
    end
    check("wd_span", (n >= 31 && n <= 34), 1'b1);
    check("wd_flag", wd_flag, 1'b1);
    wait_load();
    rreg(rsu_pkg::REG_CAUSE, d);
    check("cause_wd", d, 32'h0000_0010);
    check("page_wd", load_page, 24'h00_0000);
    rreg(rsu_pkg::REG_READBACK_LO, d);
    check("readback_factory", d, cfg[31:0]);
  endtask

  task automatic t_factory();
    int t;
    t = to_seen;
    enter_user();
    repeat (80) @(posedge clk_in);
    check("wd_factory_idle", to_seen, t);
    rreg(rsu_pkg::REG_STATE, d);
    check("state_factory", d, 32'h0000_0001);
  endtask

  task automatic t_clear();
    int t;
    arm_app();
    rsu_fabric_model_inst.pulse_reload(8);
    wait_load();
    enter_user();
    t = to_seen;
    repeat (6) begin
      rsu_fabric_model_inst.pulse_clear(7);
      repeat (4) @(posedge clk_in);
    end
    check("wd_cleared", to_seen, t);
    rreg(rsu_pkg::REG_STATE, d);
    check("state_app", d, 32'h0000_0007);
    wait_load();
    check("wd_flag_clear", wd_flag, 1'b1);
  endtask

  task automatic t_errors();
    logic [31:0] exp [3] = '{32'h0000_0008, 32'h0000_0002, 32'h0000_0001};
    for (int i = 0; i < 3; i++) begin
      arm_app();
      rsu_fabric_model_inst.pulse_reload(7);
      wait_load();
      @(posedge clk_in);
      err_act[i] <= 1'b1;
      repeat (3) @(posedge clk_in);
      err_act <= 3'b000;
      wait_load();
      rreg(rsu_pkg::REG_CAUSE, d);
      check("cause_err", d, exp[i]);
      check("page_err", load_page, 24'h00_0000);
      check("app_err", app_image, 1'b0);
      check("flag_err", wd_flag, 1'b0);
    end
  endtask

  // fabric and external reload hits land in one cycle; the reload must win
  task automatic t_priority();
    arm_app();
    fork
      rsu_fabric_model_inst.pulse_reload(7);
      begin
        repeat (7) @(posedge clk_in);
        err_act[0] <= 1'b1;
        repeat (3) @(posedge clk_in);
        err_act[0] <= 1'b0;
      end
    join
    wait_load();
    rreg(rsu_pkg::REG_CAUSE, d);
    check("cause_prio", d, 32'h0000_0008);
    check("app_prio", app_image, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cfg = '{wd_timer: 12'h004, wd_en: 1'b1, page: 24'h12_3456, app: 1'b1};
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset_regs();
    t_irq();
    t_fabric();
    t_expiry();
    t_factory();
    t_clear();
    t_errors();
    t_priority();
    report_and_stop();
  end
endmodule
`default_nettype wire
